/* pad_model.sv */
// pad and outside-line model for one 8-bit port
`timescale 1ns/1ps
module pad_model (
    input wire logic mclk,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pullEn,
    input wire logic [7:0] extVal,
    input wire logic [7:0] extEn,
    output logic [7:0] padLevel
);
    logic [7:0] floatPat_q = 8'h55;
    // a floating pad flips every cycle so no stale level passes by luck
    always_ff @(posedge mclk) begin
        floatPat_q <= ~floatPat_q;
    end
    // device drive wins, then an outside driver, then pull-up, else float
    assign padLevel = (pinOe & pinOut) | (~pinOe & extEn & extVal)
        | (~pinOe & ~extEn & pullEn) | (~pinOe & ~extEn & ~pullEn & floatPat_q);
endmodule : pad_model

/* pin_override_cell.sv */
// one pin: merges port register values with an override group
`timescale 1ns/1ps
module pin_override_cell (
    input wire logic portOut,
    input wire logic portDir,
    input wire port_override_pkg::override_t ovr,
    input wire logic openDrain,
    output port_override_pkg::pin_drive_t drive
);
    import port_override_pkg::*;
    wire logic dirEff;
    wire logic valEff;
    wire logic pullRaw;
    // override value wins when its enable is high
    assign dirEff = ovr.directionOverrideEn ? ovr.directionOverrideVal
                                            : portDir; // see R15
    assign valEff = ovr.pinvalueOverrideEn ? ovr.pinvalueOverrideVal
                                           : portOut; // see R15
    // pull-up only on an input pin driven high by the port register
    assign pullRaw = ~dirEff & portOut;
    assign drive.pullEn = ovr.pullupOverrideEn ? ovr.pullupOverrideVal
                                               : pullRaw; // see R15
    assign drive.inEn = ovr.inputEnableOverrideEn
                        ? ovr.inputEnableOverrideVal : 1'b1; // see R15
    // open drain: only ever pull low, never drive high
    assign drive.outVal = openDrain ? 1'b0 : valEff; // see R03
    assign drive.outEn = openDrain ? ~valEff : dirEff; // see R03
endmodule : pin_override_cell

/* port_alt_function_override.sv */
// alternate function override for ports C and D
//
// Behaviour
// R01: two-wire enable hands port C bit 1 to the two-wire data line.
// R02: two-wire enable hands port C bit 0 to the two-wire clock line.
// R03: two-wire pins only pull low or release, never drive high.
// R04: two-wire pins keep pull-up from their own port output bits.
// R05: oscillator select: port C 7,6 pull-up off, input, digital input off.
// R06: test port: C5 pull-up on input; C4 drives test data in shift.
// R07: port D bit 5 carries timer1 compare A when direction is output.
// R08: port D bit 4 carries timer1 compare B when direction is output.
// R09: port D 7,5,4 output value follows enabled compare outputs.
// R10: port D 7..4 never override pull/dir/input; D6 feeds capture.
// R11: port D bits 3 and 2 feed external interrupt one and zero.
// R12: transmitter enable forces port D bit 1 to output.
// R13: receiver enable forces port D bit 0 to input.
// R14: forced-input receive pin keeps pull-up from its port output bit.
// R15: each override value applies while its enable is high.
`timescale 1ns/1ps
`include "port_override_cfg.svh"
module port_alt_function_override #(
    parameter int WIDTH = `PORT_WIDTH
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] portcOut,
    input wire logic [WIDTH-1:0] portcDir,
    input wire logic [WIDTH-1:0] portdOut,
    input wire logic [WIDTH-1:0] portdDir,
    input wire logic [WIDTH-1:0] portcPinIn,
    input wire logic [WIDTH-1:0] portdPinIn,
    input wire logic twowireEnable,
    input wire logic twowireSdaOut,
    input wire logic twowireSclOut,
    input wire logic asyncTimerOscSelect,
    input wire logic testPortEnable,
    input wire logic testShiftIr,
    input wire logic testShiftDr,
    input wire logic testDataOut,
    input wire logic timer1CompareOutA,
    input wire logic timer1CompareEnA,
    input wire logic timer1CompareOutB,
    input wire logic timer1CompareEnB,
    input wire logic timer2CompareOut,
    input wire logic timer2CompareEn,
    input wire logic txEnable,
    input wire logic txData,
    input wire logic rxEnable,
    output logic [WIDTH-1:0] portcPinOut,
    output logic [WIDTH-1:0] portcPinOe,
    output logic [WIDTH-1:0] portcPullEn,
    output logic [WIDTH-1:0] portdPinOut,
    output logic [WIDTH-1:0] portdPinOe,
    output logic [WIDTH-1:0] portdPullEn,
    output logic [WIDTH-1:0] portcSyncedIn,
    output logic [WIDTH-1:0] portdSyncedIn,
    output logic twowireSdaIn,
    output logic twowireSclIn,
    output logic testDataIn,
    output logic timer1CaptureInput,
    output logic extIrqZero,
    output logic extIrqOne,
    output logic rxData
);
    import port_override_pkg::*;

    // fixed bit positions need a full eight-bit port
    if (WIDTH != 8) begin : g_width_check
        $error("port width must be 8");
    end

    override_t ovrC [WIDTH];
    override_t ovrD [WIDTH];
    pin_drive_t drvC [WIDTH];
    pin_drive_t drvD [WIDTH];
    logic [WIDTH-1:0] odC;
    logic [WIDTH-1:0] odD;
    logic [WIDTH-1:0] inEnC;
    logic [WIDTH-1:0] inEnD;
    logic [WIDTH-1:0] syncC1_q;
    logic [WIDTH-1:0] syncC2_q;
    logic [WIDTH-1:0] syncD1_q;
    logic [WIDTH-1:0] syncD2_q;
    logic [WIDTH-1:0] cOut_d;
    logic [WIDTH-1:0] cOe_d;
    logic [WIDTH-1:0] cPull_d;
    logic [WIDTH-1:0] dOut_d;
    logic [WIDTH-1:0] dOe_d;
    logic [WIDTH-1:0] dPull_d;
    wire logic testShift;

    assign testShift = testShiftIr | testShiftDr;

    // port C override groups; the two-wire pins take their pull-up straight
    // from the port output bit, whatever the direction bit says
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            ovrC[i] = '0;
        end
        ovrC[`PC_SDA_BIT].pinvalueOverrideEn = twowireEnable; // see R01
        ovrC[`PC_SDA_BIT].pinvalueOverrideVal = twowireSdaOut; // see R01
        ovrC[`PC_SCL_BIT].pinvalueOverrideEn = twowireEnable; // see R02
        ovrC[`PC_SCL_BIT].pinvalueOverrideVal = twowireSclOut; // see R02
        ovrC[`PC_SDA_BIT].pullupOverrideEn = twowireEnable; // see R04
        ovrC[`PC_SDA_BIT].pullupOverrideVal =
            portcOut[`PC_SDA_BIT]; // see R04
        ovrC[`PC_SCL_BIT].pullupOverrideEn = twowireEnable; // see R04
        ovrC[`PC_SCL_BIT].pullupOverrideVal =
            portcOut[`PC_SCL_BIT]; // see R04
        for (int i = `PC_TOSC1_BIT; i <= `PC_TOSC2_BIT; i++) begin
            ovrC[i].pullupOverrideEn = asyncTimerOscSelect; // see R05
            ovrC[i].directionOverrideEn = asyncTimerOscSelect; // see R05
            ovrC[i].inputEnableOverrideEn = asyncTimerOscSelect; // see R05
        end
        ovrC[`PC_TDI_BIT].pullupOverrideEn = testPortEnable; // see R06
        ovrC[`PC_TDI_BIT].pullupOverrideVal = 1'b1; // see R06
        ovrC[`PC_TDI_BIT].directionOverrideEn = testPortEnable; // see R06
        ovrC[`PC_TDI_BIT].inputEnableOverrideEn = testPortEnable; // see R06
        ovrC[`PC_TDO_BIT].pullupOverrideEn = testPortEnable; // see R06
        ovrC[`PC_TDO_BIT].directionOverrideEn = testPortEnable; // see R06
        ovrC[`PC_TDO_BIT].directionOverrideVal = testShift; // see R06
        ovrC[`PC_TDO_BIT].pinvalueOverrideEn = testPortEnable; // see R06
        ovrC[`PC_TDO_BIT].pinvalueOverrideVal = testDataOut; // see R06
        ovrC[`PC_TDO_BIT].inputEnableOverrideEn = testPortEnable; // see R06
    end

    // port D groups: value overrides on bits 7, 5 and 4 and on transmit pin D1
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            ovrD[i] = '0; // see R10
        end
        ovrD[`PD_OC2_BIT].pinvalueOverrideEn = timer2CompareEn; // see R09
        ovrD[`PD_OC2_BIT].pinvalueOverrideVal = timer2CompareOut; // see R09
        ovrD[`PD_OCA_BIT].pinvalueOverrideEn = timer1CompareEnA; // see R07
        ovrD[`PD_OCA_BIT].pinvalueOverrideVal = timer1CompareOutA; // see R07
        ovrD[`PD_OCB_BIT].pinvalueOverrideEn = timer1CompareEnB; // see R08
        ovrD[`PD_OCB_BIT].pinvalueOverrideVal = timer1CompareOutB; // see R08
        ovrD[`PD_TX_BIT].directionOverrideEn = txEnable; // see R12
        ovrD[`PD_TX_BIT].directionOverrideVal = 1'b1; // see R12
        ovrD[`PD_TX_BIT].pinvalueOverrideEn = txEnable;
        ovrD[`PD_TX_BIT].pinvalueOverrideVal = txData;
        // pull-up left to the cell so it tracks the port bit
        ovrD[`PD_RX_BIT].directionOverrideEn = rxEnable; // see R13 R14
    end

    // open-drain mode only on the two-wire pins
    always_comb begin
        odC = '0;
        odC[`PC_SDA_BIT] = twowireEnable; // see R03
        odC[`PC_SCL_BIT] = twowireEnable; // see R03
        odD = '0;
    end

    // one merge cell per pin
    for (genvar g = 0; g < WIDTH; g++) begin : g_pin
        pin_override_cell u_c (
            .portOut(portcOut[g]),
            .portDir(portcDir[g]),
            .ovr(ovrC[g]),
            .openDrain(odC[g]),
            .drive(drvC[g])
        );
        pin_override_cell u_d (
            .portOut(portdOut[g]),
            .portDir(portdDir[g]),
            .ovr(ovrD[g]),
            .openDrain(odD[g]),
            .drive(drvD[g])
        );
        assign cOut_d[g] = drvC[g].outVal;
        assign cOe_d[g] = drvC[g].outEn;
        assign cPull_d[g] = drvC[g].pullEn;
        assign inEnC[g] = drvC[g].inEn;
        assign dOut_d[g] = drvD[g].outVal;
        assign dOe_d[g] = drvD[g].outEn;
        assign dPull_d[g] = drvD[g].pullEn;
        assign inEnD[g] = drvD[g].inEn;
    end

    // pin drives are registered so pads see clean levels
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            portcPinOut <= `REG_RESET;
            portcPinOe <= `REG_RESET;
            portcPullEn <= `REG_RESET;
            portdPinOut <= `REG_RESET;
            portdPinOe <= `REG_RESET;
            portdPullEn <= `REG_RESET;
        end else begin
            portcPinOut <= cOut_d;
            portcPinOe <= cOe_d;
            portcPullEn <= cPull_d;
            portdPinOut <= dOut_d;
            portdPinOe <= dOe_d;
            portdPullEn <= dPull_d;
        end
    end

    // two-flop synchronisers; pins are asynchronous to mclk
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            syncC1_q <= `REG_RESET;
            syncC2_q <= `REG_RESET;
            syncD1_q <= `REG_RESET;
            syncD2_q <= `REG_RESET;
        end else begin
            syncC1_q <= portcPinIn;
            syncC2_q <= syncC1_q;
            syncD1_q <= portdPinIn;
            syncD2_q <= syncD1_q;
        end
    end

    // disabled digital inputs read as zero on the synced port buses, avoiding floating pins
    assign portcSyncedIn = syncC2_q & inEnC; // see R05 R06
    assign portdSyncedIn = syncD2_q & inEnD;
    assign twowireSdaIn = syncC2_q[`PC_SDA_BIT]; // see R01
    assign twowireSclIn = syncC2_q[`PC_SCL_BIT]; // see R02
    assign testDataIn = syncC2_q[`PC_TDI_BIT];
    assign timer1CaptureInput = syncD2_q[`PD_CAP_BIT]; // see R10
    assign extIrqZero = syncD2_q[`PD_IRQ0_BIT]; // see R11
    assign extIrqOne = syncD2_q[`PD_IRQ1_BIT]; // see R11
    assign rxData = syncD2_q[`PD_RX_BIT];

    // pin guards; drive is registered, so each looks one cycle back
    a_sda_no_high: assert property ( // see R03
        @(posedge mclk) disable iff (!rstn)
        $past(twowireEnable) && $past(rstn)
        |-> !(portcPinOe[`PC_SDA_BIT] && portcPinOut[`PC_SDA_BIT]))
        else $error("two-wire data pin driven high");
    a_scl_pull_low: assert property ( // see R02
        @(posedge mclk) disable iff (!rstn)
        $past(twowireEnable) && !$past(twowireSclOut) && $past(rstn)
        |-> portcPinOe[`PC_SCL_BIT])
        else $error("two-wire clock not pulled low");
    a_sda_pull_port: assert property ( // see R04
        @(posedge mclk) disable iff (!rstn)
        $past(twowireEnable) && $past(rstn)
        |-> portcPullEn[`PC_SDA_BIT] == $past(portcOut[`PC_SDA_BIT]))
        else $error("two-wire data pull-up not from port bit");
    a_scl_pull_port: assert property ( // see R04
        @(posedge mclk) disable iff (!rstn)
        $past(twowireEnable) && $past(rstn)
        |-> portcPullEn[`PC_SCL_BIT] == $past(portcOut[`PC_SCL_BIT]))
        else $error("two-wire clock pull-up not from port bit");
    a_osc_pins_off: assert property ( // see R05
        @(posedge mclk) disable iff (!rstn)
        $past(asyncTimerOscSelect) && $past(rstn)
        |-> portcPinOe[7:6] == 2'h0 && portcPullEn[7:6] == 2'h0)
        else $error("oscillator pins not released");
    a_tdo_shift_out: assert property ( // see R06
        @(posedge mclk) disable iff (!rstn)
        $past(testPortEnable) && $past(rstn)
        |-> portcPinOe[`PC_TDO_BIT] == $past(testShift)
            && portcPinOut[`PC_TDO_BIT] == $past(testDataOut))
        else $error("test data out pin wrong");
    a_oca_value: assert property ( // see R07 R09
        @(posedge mclk) disable iff (!rstn)
        $past(timer1CompareEnA) && $past(rstn)
        |-> portdPinOut[`PD_OCA_BIT] == $past(timer1CompareOutA)
            && portdPinOe[`PD_OCA_BIT] == $past(portdDir[`PD_OCA_BIT]))
        else $error("compare A pin wrong");
    a_tx_forced_out: assert property ( // see R12
        @(posedge mclk) disable iff (!rstn)
        $past(txEnable) && $past(rstn) |-> portdPinOe[`PD_TX_BIT])
        else $error("transmit pin not output");
    a_rx_forced_in: assert property ( // see R13 R14
        @(posedge mclk) disable iff (!rstn)
        $past(rxEnable) && $past(rstn)
        |-> !portdPinOe[`PD_RX_BIT]
            && portdPullEn[`PD_RX_BIT] == $past(portdOut[`PD_RX_BIT]))
        else $error("receive pin not input");
endmodule : port_alt_function_override

/* port_override_cfg.svh */
// bit positions and reset values for the port override block
`ifndef PORT_OVERRIDE_CFG_SVH
`define PORT_OVERRIDE_CFG_SVH
`define PORT_WIDTH 8
`define PC_SCL_BIT 0
`define PC_SDA_BIT 1
`define PC_TDO_BIT 4
`define PC_TDI_BIT 5
`define PC_TOSC1_BIT 6
`define PC_TOSC2_BIT 7
`define PD_RX_BIT 0
`define PD_TX_BIT 1
`define PD_IRQ0_BIT 2
`define PD_IRQ1_BIT 3
`define PD_OCB_BIT 4
`define PD_OCA_BIT 5
`define PD_CAP_BIT 6
`define PD_OC2_BIT 7
`define REG_RESET 8'h00
`endif

/* port_override_pkg.sv */
// types shared by the port override block
package port_override_pkg;
    // one override group for one pin
    typedef struct packed {
        logic pullupOverrideEn;
        logic pullupOverrideVal;
        logic directionOverrideEn;
        logic directionOverrideVal;
        logic pinvalueOverrideEn;
        logic pinvalueOverrideVal;
        logic inputEnableOverrideEn;
        logic inputEnableOverrideVal;
    } override_t;
    // resolved drive of one pin
    typedef struct packed {
        logic outVal;
        logic outEn;
        logic pullEn;
        logic inEn;
    } pin_drive_t;
endpackage : port_override_pkg

/* tb.sv */
// self-checking bench for the port override block
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [47:0] drv;
        logic [22:0] syn;
        logic [22:0] synMask;
    } note_t;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] regs = 32'h0;
    logic [16:0] ctl = 17'h0;
    logic [31:0] ext = 32'h0;
    logic [7:0] cOut, cOe, cPull, dOut, dOe, dPull, cPad, dPad, cSyn, dSyn;
    wire logic [6:0] single;
    logic strobe = 1'b0;
    int error_cnt = 0;
    int checks_done = 0;
    note_t notes[$];
    note_t cur;
    always #5 mclk = ~mclk;
    port_alt_function_override dut (.mclk(mclk), .rstn(rstn),
        .portcOut(regs[31:24]), .portcDir(regs[23:16]),
        .portdOut(regs[15:8]), .portdDir(regs[7:0]),
        .portcPinIn(cPad), .portdPinIn(dPad),
        .twowireEnable(ctl[0]), .twowireSdaOut(ctl[1]),
        .twowireSclOut(ctl[2]), .asyncTimerOscSelect(ctl[3]),
        .testPortEnable(ctl[4]), .testShiftIr(ctl[5]), .testShiftDr(ctl[6]),
        .testDataOut(ctl[7]), .timer1CompareOutA(ctl[8]),
        .timer1CompareEnA(ctl[9]), .timer1CompareOutB(ctl[10]),
        .timer1CompareEnB(ctl[11]), .timer2CompareOut(ctl[12]),
        .timer2CompareEn(ctl[13]), .txEnable(ctl[14]), .txData(ctl[15]),
        .rxEnable(ctl[16]), .portcPinOut(cOut), .portcPinOe(cOe),
        .portcPullEn(cPull), .portdPinOut(dOut), .portdPinOe(dOe),
        .portdPullEn(dPull), .portcSyncedIn(cSyn), .portdSyncedIn(dSyn),
        .twowireSdaIn(single[6]), .twowireSclIn(single[5]),
        .testDataIn(single[4]), .timer1CaptureInput(single[3]),
        .extIrqZero(single[2]), .extIrqOne(single[1]), .rxData(single[0]));
    pad_model padC (.mclk(mclk), .pinOut(cOut), .pinOe(cOe), .pullEn(cPull),
        .extVal(ext[31:24]), .extEn(ext[23:16]), .padLevel(cPad));
    pad_model padD (.mclk(mclk), .pinOut(dOut), .pinOe(dOe), .pullEn(dPull),
        .extVal(ext[15:8]), .extEn(ext[7:0]), .padLevel(dPad));

    // expected pad drive and synced levels, worked out bit by bit
    function automatic note_t build(input logic [31:0] r,
        input logic [16:0] k, input logic [31:0] e);
        logic [7:0] co, cd, dr, dd, xo, xe, xp, yo, ye, yp, cIn, lc, mc, ld, md;
        note_t n;
        {co, cd, dr, dd} = r;
        xo = co;
        xe = cd;
        xp = ~cd & co;
        cIn = 8'hFF;
        if (k[0]) begin
            xo[1:0] = 2'h0;
            xe[1:0] = {~k[1], ~k[2]};
            xp[1:0] = co[1:0];
        end
        if (k[3]) begin
            xe[7:6] = 2'h0;
            xp[7:6] = 2'h0;
            cIn[7:6] = 2'h0;
        end
        if (k[4]) begin
            xo[4] = k[7];
            xe[5:4] = {1'b0, k[5] | k[6]};
            xp[5:4] = 2'h2;
            cIn[5:4] = 2'h0;
        end
        yo = dr;
        ye = dd;
        if (k[9]) yo[5] = k[8];
        if (k[11]) yo[4] = k[10];
        if (k[13]) yo[7] = k[12];
        if (k[14]) begin
            yo[1] = k[15];
            ye[1] = 1'b1;
        end
        if (k[16]) ye[0] = 1'b0;
        yp = ~ye & dr;
        lc = (xe & xo) | (~xe & e[23:16] & e[31:24]) | (~xe & ~e[23:16] & xp);
        mc = xe | e[23:16] | xp;
        ld = (ye & yo) | (~ye & e[7:0] & e[15:8]) | (~ye & ~e[7:0] & yp);
        md = ye | e[7:0] | yp;
        n.drv = {xo, xe, xp, yo, ye, yp};
        n.syn = {lc & cIn, ld, lc[1], lc[0], lc[5], ld[6], ld[2], ld[3],
            ld[0]};
        n.synMask = {mc | ~cIn, md, mc[1], mc[0], mc[5], md[6], md[2], md[3],
            md[0]};
        return n;
    endfunction : build

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // watcher: one note off the queue for each result strobe
    always @(negedge mclk) begin
        if (strobe && notes.size() == 0) begin
            error_cnt++;
        end else if (strobe) begin
            cur = notes.pop_front();
            check({24'h0, cOut, cOe, cPull},
                {24'h0, cur.drv[47:24]});
            check({24'h0, dOut, dOe, dPull},
                {24'h0, cur.drv[23:0]});
            check({25'h0, {cSyn, dSyn, single} & cur.synMask},
                {25'h0, cur.syn & cur.synMask});
        end
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        give_verdict();
    end

    // reset, then random settings held long enough for the synchronisers
    initial begin
        void'($urandom(32'h7ABF));
        repeat (6) @(posedge mclk);
        notes.push_back(note_t'{48'h0, 23'h0, 23'h7FFFFF});
        strobe <= 1'b1;
        @(posedge mclk);
        strobe <= 1'b0;
        @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 80; i++) begin
            @(posedge mclk);
            regs <= $urandom;
            ctl <= 17'($urandom);
            ext <= $urandom;
            @(posedge mclk);
            notes.push_back(build(regs, ctl, ext));
            repeat (3) @(posedge mclk);
            strobe <= 1'b1;
            @(posedge mclk);
            strobe <= 1'b0;
        end
        @(posedge mclk);
        give_verdict();
    end
endmodule : tb
